// *** src/tem_match_out.sv ***
// External match output control with an APB register slave
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tem_match_out
	import tem_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Timer side, same clock domain
	input wire logic [31:0] i_timer_count_value,
	input wire logic [31:0] i_match_value_0,
	input wire logic [31:0] i_match_value_1,
	input wire logic [31:0] i_match_value_2,
	input wire logic [31:0] i_match_value_3,
	input wire logic [3:0] i_pwm_enable,
	input wire logic [3:0] i_pwm_level,
	// Match pins
	output logic [3:0] o_match_pin
);
	// ==========================================================
	// Reset release
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_b;

	// Asserts at once, releases two edges later
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_b = rst_sync_reg;

	// ==========================================================
	// APB decode
	logic [11:0] ctrl_reg;
	logic [11:0] ctrl_next;
	wire sel_ctrl = (i_paddr == TEM_OFF_CTRL);
	wire wr_ctrl = i_psel && i_penable && i_pwrite && sel_ctrl;

	// Zero-wait slave; unmapped addresses answer with an error
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !sel_ctrl;
	assign o_prdata = (i_psel && sel_ctrl) ? {20'h0_0000, ctrl_reg} : 32'h0000_0000;

	// ==========================================================
	// Match comparison
	wire [31:0] match_val [TEM_NUM_CH];
	assign match_val[0] = i_match_value_0;
	assign match_val[1] = i_match_value_1;
	assign match_val[2] = i_match_value_2;
	assign match_val[3] = i_match_value_3;

	logic [3:0] hit;
	logic [3:0] bit_next;

	// Per-channel action; a match outranks a write to the same bit so events are not lost
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = i_pwdata[11:0] & TEM_CTRL_WMASK[11:0];
		end
		for (int ch = 0; ch < TEM_NUM_CH; ch++) begin
			hit[ch] = (i_timer_count_value == match_val[ch]) && !i_pwm_enable[ch];
			bit_next[ch] = ctrl_next[TEM_BIT_MATCH_LO + ch];
			if (hit[ch]) begin
				unique case (tem_action_e'(ctrl_reg[TEM_FIELD_ACT_LO + 2*ch +: 2]))
					TEM_ACT_NONE: bit_next[ch] = ctrl_reg[ch];
					TEM_ACT_LOW: bit_next[ch] = 1'b0;
					TEM_ACT_HIGH: bit_next[ch] = 1'b1;
					TEM_ACT_TOGGLE: bit_next[ch] = ~ctrl_reg[ch];
				endcase
			end
		end
		ctrl_next[3:0] = bit_next;
	end

	// Control and match bit storage
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= TEM_CTRL_RESET[11:0];
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Pins follow match bits, or the PWM level when the channel is in PWM mode
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_match_pin <= 4'h0;
		end else begin
			o_match_pin <= (i_pwm_enable & i_pwm_level) | (~i_pwm_enable & ctrl_next[3:0]);
		end
	end
endmodule : tem_match_out

// *** src/tem_pkg.sv ***
// Constants for the timer external match output block
//
// Behaviour
// - Channel 2 action field at bits 9:8 selects none, low, high or toggle on a channel 2 match.
// - Channel 1 action field at bits 7:6 selects none, low, high or toggle on a channel 1 match.
// - Channel 0 action field at bits 5:4 selects none, low, high or toggle on a channel 0 match.
// - A count equal to match value 3 updates match bit 3 by its action field, and bit 3 drives pin 3.
// - A count equal to match value 2 updates match bit 2 by its action field, and bit 2 drives pin 2.
// - A count equal to match value 1 updates match bit 1; the bit is read/write and resets to zero.
// - Channel 3 action field sits at bits 11:10 with the same encoding; bits 31:12 read as zero.
// - A channel set as PWM output has its pin driven by the PWM level instead; its match bit ignores matches and changes only on a register write.
package tem_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] TEM_OFF_CTRL = 12'h030;
	localparam logic [31:0] TEM_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] TEM_CTRL_WMASK = 32'h0000_0FFF;
	localparam int TEM_BIT_MATCH_LO = 0;
	localparam int TEM_FIELD_ACT_LO = 4;
	localparam int TEM_NUM_CH = 4;
	// ==========================================================
	// Action encoding
	typedef enum logic [1:0] {
		TEM_ACT_NONE = 2'h0,
		TEM_ACT_LOW = 2'h1,
		TEM_ACT_HIGH = 2'h2,
		TEM_ACT_TOGGLE = 2'h3
	} tem_action_e;
endpackage : tem_pkg

// *** testbench/tb_top.sv ***
// Testbench for the match output block
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 0, i_rst_b = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, er, o_pready, o_pslverr;
	logic [11:0] i_paddr = 12'h0;
	logic [31:0] i_pwdata = 32'h0, i_timer_count_value = 32'h0, rd, o_prdata;
	wire logic [31:0] i_match_value_0 = 32'h10, i_match_value_1 = 32'h10;
	wire logic [31:0] i_match_value_2 = 32'h10, i_match_value_3 = 32'h10;
	logic [3:0] i_pwm_enable = 4'h0, i_pwm_level = 4'h0, o_match_pin, p = 4'h0;
	int n_fail = 0, n_tests = 0;
	tem_match_out u_tem_match_out (.*);
	tem_pin_load u_tem_pin_load (.i_match_pin(o_match_pin));
	initial forever #2.5 i_clk = ~i_clk;
	task chk(string nm, logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin n_fail++; $display("unexpected %s exp %h seen %h", nm, e, s); end
	endtask : chk
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge i_clk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
		@(posedge i_clk) i_penable <= 1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		{rd, er} = {o_prdata, o_pslverr};
		{i_psel, i_penable} <= 2'h0;
	endtask : apb
	// One cycle of count equal to every match value, then the pins are judged
	task hit;
		@(posedge i_clk) i_timer_count_value <= 32'h10;
		@(posedge i_clk) i_timer_count_value <= 32'h0;
		@(negedge i_clk) chk("pin", 32'(o_match_pin), 32'(p));
	endtask : hit
	task t_act;
		for (int i = 0; i < 4; i++) begin
			apb(1, 12'h030, {20'h0, {4{2'(8'h36 >> 2 * i)}}, p});
			p = 4'(16'hFF0F >> 4 * i); // High, low, toggle, none in turn
			hit;
		end
		$display("actions done");
	endtask : t_act
	task t_reg;
		apb(1, 12'h030, 32'hFFFF_FFFA);
		apb(1, 12'h034, 32'h0);
		chk("err", {rd[30:0], er}, 32'h1);
		apb(0, 12'h030, 32'h0);
		chk("ctrl", rd, 32'h0000_0FFA);
		{i_pwm_enable, i_pwm_level} <= 8'hF5;
		p = 4'h5;
		hit;
		@(posedge i_clk) i_pwm_enable <= 4'h0;
		repeat (2) @(negedge i_clk);
		chk("frozen", 32'(o_match_pin), 32'hA);
		$display("registers done");
	endtask : t_reg
	task tally_and_finish;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1;
		repeat (3) @(posedge i_clk);
		t_act;
		t_reg;
		tally_and_finish;
	end
	initial #20000 begin n_fail++; tally_and_finish; end
endmodule : tb_top
bind tem_match_out tem_match_out_props u_props (.*);

// *** testbench/tem_match_out_props.sv ***
// Port checker for the match output block
`timescale 1ns/1ps
module tem_match_out_props (
	input wire logic i_clk, i_rst_b, i_psel, i_penable, i_pwrite, o_pslverr, o_pready,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_timer_count_value, i_match_value_0, i_match_value_1,
	input wire logic [31:0] i_match_value_2, i_match_value_3,
	input wire logic [31:0] o_prdata,
	input wire logic [3:0] i_pwm_enable, i_pwm_level, o_match_pin);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire hit = i_psel && i_paddr == 12'h030; // Zero wait: decode alone decides
	a_err_map: assert property (i_penable |-> o_pslverr == !hit) else $error("err");
	a_rsvd_zero: assert property (o_prdata[31:12] == 20'h0) else $error("rsvd");
	a_pin_bit: assert property (hit && $past(i_pwm_enable) == 4'h0
		&& i_pwm_enable == 4'h0 |-> o_prdata[3:0] == o_match_pin) else $error("bit");
	a_pwm_pin: assert property ($past(i_pwm_enable) == 4'hF
		|-> o_match_pin == $past(i_pwm_level)) else $error("pwm");
	// Without a match, a write or PWM on either side of the edge, the pins must hold
	wire quiet = i_timer_count_value != i_match_value_0 && i_timer_count_value != i_match_value_1
		&& i_timer_count_value != i_match_value_2 && i_timer_count_value != i_match_value_3
		&& !(i_psel && i_penable && i_pwrite) && i_pwm_enable == 4'h0;
	a_pin_hold: assert property (quiet && $past(i_pwm_enable) == 4'h0
		|=> $stable(o_match_pin)) else $error("hold");
	a_ready_high: assert property (o_pready) else $error("ready");
	c_err: cover property (o_pslverr);
	c_pwm: cover property (i_pwm_enable == 4'hF);
	c_pin: cover property ($changed(o_match_pin));
endmodule : tem_match_out_props

// *** testbench/tem_pin_load.sv ***
// Receiver on the match pins, sensing only
`timescale 1ns/1ps
module tem_pin_load (input wire logic [3:0] i_match_pin);
endmodule : tem_pin_load
